// ### pkg/rsc_pkg.sv
// Constants, types and reset values of the reset sequence controller.
// Assumes the CPU clock is REF_CLK, so one clock cycle equals two half periods.
// Contract
// [R1] Reset low, powerdown pin low: asynchronous reset.
// [R2] Async exit: restart, capture config, idle strobes.
// [R3] Every reset exit fetches from address zero.
// [R4] Reset low, powerdown high, 4 half-periods: synchronous.
// [R5] Sync entry: I/O high impedance, reset output low.
// [R6] Within 12 half-periods abort holds and bus.
// [R7] Pull-down only if bidir bit set; reset clears it.
// [R8] After 16 half-periods run 1024 half-period sequence.
// [R9] Sample 8 half-periods later: short, or long too.
// [R10] Long reset makes config bits 15:13 transparent.
// [R11] Bidir short pulse: hold input low until sequence end.
// [R12] Transparency ends 3-4 half-periods after input high.
// [R13] Hold until input high, then flash init.
// [R14] Reset input low enables powerdown pin pull-down.
// [R15] Powerdown low during sync reset: asynchronous, completes.
// [R16] Software reset completes regardless of powerdown pin.
// [R17] Powerdown influence qualified by filtered reset input.
// [R18] Software reset instruction starts a short-like sequence.
// [R19] Software reset: capture bits 12:8, set 7:2.
// [R20] Software bidir drive only while powerdown pin high.
// [R21] Too-short escaped pulse resets only the flash.
// [R22] Board holds reset input low beyond 500 ns.
// [R23] External boot: release 3-8 half-periods after input.
// [R24] Reset output low until end-of-init instruction.
// [R25] Classification flags readable until next reset.
package rsc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TCL_NS        = CLK_PERIOD_NS / 2;
	localparam int MIN_LOW_TCL   = 4;
	localparam int WIN_TCL       = 12;
	localparam int SEQ_TCL       = 1024;
	localparam int SMP_TCL       = 8;
	localparam int REL_TCL       = 3;
	localparam int CNT_MIN_LOW   = (MIN_LOW_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_WIN       = (WIN_TCL * TCL_NS) / CLK_PERIOD_NS;
	localparam int CNT_SEQ       = (SEQ_TCL * TCL_NS) / CLK_PERIOD_NS;
	localparam int CNT_SMP       = (SMP_TCL * TCL_NS) / CLK_PERIOD_NS;
	localparam int CNT_REL       = (REL_TCL * TCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 10;
	localparam int LOW_W         = 4;
	localparam int CFG_W         = 16;
	localparam int ADDR_W        = 24;
	localparam int SYSTEM_CONFIG_REGISTER_W      = 16;
	localparam int SYSTEM_CONFIG_REGISTER_BIDIR_BIT = 3;
	localparam int CFG_CLK_HI    = 15;
	localparam int CFG_CLK_LO    = 13;
	localparam int CFG_SW_HI     = 12;
	localparam int CFG_SW_LO     = 8;
	localparam int CFG_ONE_HI    = 7;
	localparam int CFG_ONE_LO    = 2;
	localparam logic [15:0] CFG_RESET    = 16'hFFFF;
	localparam logic [5:0]  CFG_SW_ONES  = 6'h3F;
	localparam logic [23:0] RESET_VECTOR = 24'h00_0000;

	typedef enum logic [2:0] {
		ST_RUN   = 3'b000,
		ST_WIN   = 3'b001,
		ST_SEQ   = 3'b010,
		ST_SMP   = 3'b011,
		ST_HOLD  = 3'b100,
		ST_REL   = 3'b101,
		ST_FLASH = 3'b110,
		ST_ASYNC = 3'b111
	} rsc_state_t;

	typedef struct packed {
		rsc_state_t              st;
		logic [CNT_W-1:0]        cnt;
		logic [ADDR_W-1:0]       fetch;
		logic                    sw;
		logic                    bidir_en;
		logic                    bidir_act;
		logic                    rst_out_n;
		logic                    pd_oe;
		logic                    rpd_pd;
		logic                    io_hz;
		logic                    abort;
		logic                    strobe_idle;
		logic                    cpu_run;
		logic                    short_f;
		logic                    long_f;
		logic                    sw_f;
		logic                    async_f;
		logic                    flash_rst;
		logic                    cap_full;
		logic                    cap_sw;
		logic                    transp;
	} rsc_ctl_t;

	localparam rsc_ctl_t RSC_CTL_RST = '{
		st: ST_ASYNC, fetch: RESET_VECTOR, io_hz: 1'b1, abort: 1'b1,
		strobe_idle: 1'b1, async_f: 1'b1, default: '0};
endpackage : rsc_pkg

// ### pkg/rsc_seq_if.sv
// Signals between the reset controller and its timer and configuration latch.
// Assumes one clock domain; the controller drives all control strobes.
`timescale 1ns/1ns
interface rsc_seq_if;
	logic                      rst_low;
	logic                      qual;
	logic                      glitch;
	logic                      cap_full;
	logic                      cap_sw;
	logic                      transp;
	logic [rsc_pkg::CFG_W-1:0] port_in;
	logic [rsc_pkg::CFG_W-1:0] cfg;

	modport tmr (input rst_low, output qual, output glitch);
	modport cfgl (input cap_full, input cap_sw, input transp, input port_in, output cfg);
	modport ctl (output rst_low, output cap_full, output cap_sw, output transp,
		output port_in, input qual, input glitch, input cfg);
endinterface : rsc_seq_if

// ### rtl/rsc_cfg_latch.sv
// Holds the system configuration captured from the configuration port.
// Assumes capture strobes are single-cycle pulses from the controller.
`timescale 1ns/1ns
module rsc_cfg_latch
	import rsc_pkg::*;
#(
	parameter int W = CFG_W
) (
	input wire logic clk,
	input wire logic rst_n,
	rsc_seq_if.cfgl  sif
);
	typedef struct packed {
		logic [W-1:0] cfg;
	} rsc_cfg_t;

	rsc_cfg_t q;
	rsc_cfg_t d;

	if (W != CFG_W) begin : g_bad_param
		$error("rsc_cfg_latch: width must match the configuration port");
	end

	always_comb begin
		d = q;
		if (sif.cap_full) begin
			d.cfg = sif.port_in; // R2
		end else if (sif.cap_sw) begin
			d.cfg[CFG_SW_HI:CFG_SW_LO] = sif.port_in[CFG_SW_HI:CFG_SW_LO]; // R19
			d.cfg[CFG_ONE_HI:CFG_ONE_LO] = CFG_SW_ONES; // R19
		end
		if (sif.transp) begin
			d.cfg[CFG_CLK_HI:CFG_CLK_LO] = sif.port_in[CFG_CLK_HI:CFG_CLK_LO]; // R10
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q.cfg <= CFG_RESET;
		end else begin
			q <= d;
		end
	end

	assign sif.cfg = q.cfg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_sw_capture: assert property ( // R19
		sif.cap_sw && !sif.cap_full |=> q.cfg[CFG_ONE_HI:CFG_ONE_LO] == CFG_SW_ONES
		&& q.cfg[CFG_SW_HI:CFG_SW_LO] == $past(sif.port_in[CFG_SW_HI:CFG_SW_LO]))
		else $error("Software reset capture is wrong.");
	chk_clk_transparent: assert property ( // R10
		sif.transp |=> q.cfg[CFG_CLK_HI:CFG_CLK_LO] == $past(sif.port_in[CFG_CLK_HI:CFG_CLK_LO]))
		else $error("Clock option bits not transparent.");
endmodule : rsc_cfg_latch

// ### rtl/rsc_low_timer.sv
// Qualifies the filtered reset input low time and flags too-short pulses.
// Assumes the filtered reset input is synchronous to clk.
`timescale 1ns/1ns
module rsc_low_timer
	import rsc_pkg::*;
#(
	parameter int MIN = CNT_MIN_LOW,
	parameter int W   = LOW_W
) (
	input wire logic clk,
	input wire logic rst_n,
	rsc_seq_if.tmr   sif
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         qual;
		logic         glitch;
	} rsc_tmr_t;

	rsc_tmr_t q;
	rsc_tmr_t d;

	if (MIN < 1 || MIN >= 2 ** W) begin : g_bad_param
		$error("rsc_low_timer: MIN does not fit the counter");
	end

	always_comb begin
		d = q;
		d.glitch = 1'b0;
		if (sif.rst_low) begin
			if (q.cnt < W'(MIN)) begin
				d.cnt = q.cnt + 1'b1;
			end
		end else begin
			d.glitch = (q.cnt != '0) && (q.cnt < W'(MIN)); // R21
			d.cnt = '0;
		end
		d.qual = sif.rst_low && (d.cnt >= W'(MIN)); // R4
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sif.qual   = q.qual;
	assign sif.glitch = q.glitch;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_min_low_time: assert property ( // R4
		$rose(sif.qual) |-> $past(sif.rst_low, 1) && $past(sif.rst_low, 2))
		else $error("Reset qualified before the minimum low time.");
	chk_short_glitch: assert property ( // R21
		(q.cnt != '0 && q.cnt < W'(MIN) && !sif.rst_low) |=> sif.glitch && !sif.qual)
		else $error("Too-short reset pulse not flagged.");
endmodule : rsc_low_timer

// ### rtl/rsc_reset_ctrl.sv
// Reset sequence controller: classifies, times and exits every kind of reset.
// Assumes all inputs are synchronous to REF_CLK and the reset input is already filtered.
`timescale 1ns/1ns
module rsc_reset_ctrl
	import rsc_pkg::*;
#(
	parameter int SEQ_CYCLES = CNT_SEQ,
	parameter int WIN_CYCLES = CNT_WIN
) (
	input  wire logic                REF_CLK,
	input  wire logic                RST_N,
	input  wire logic                FILTERED_RESET_IN_N,
	input  wire logic                RESET_POWERDOWN_PIN,
	input  wire logic                EXTERNAL_ACCESS_SELECT,
	input  wire logic                FLASH_INIT_DONE,
	input  wire logic                SOFTWARE_RESET_INSTRUCTION,
	input  wire logic                END_OF_INIT_INSTRUCTION,
	input  wire logic                SYSTEM_CONFIG_REGISTER_WR,
	input  wire logic [SYSTEM_CONFIG_REGISTER_W-1:0] SYSTEM_CONFIG_REGISTER_WDATA,
	input  wire logic [CFG_W-1:0]    CONFIG_PORT,
	output logic                     RESET_OUT_N,
	output logic                     RESET_IN_N_O,
	output logic                     RESET_IN_N_OE,
	output logic                     RPD_PULLDOWN_EN,
	output logic                     IO_HIGHZ,
	output logic                     BUS_ABORT,
	output logic                     STROBES_IDLE,
	output logic                     CPU_RUN,
	output logic [ADDR_W-1:0]        FETCH_ADDR,
	output logic                     FLASH_RESET,
	output logic                     BIDIR_RESET_ENABLE,
	output logic [CFG_W-1:0]         CONFIG_LATCHED,
	output logic                     CONFIG_CLK_TRANSPARENT,
	output logic                     SHORT_RESET_FLAG,
	output logic                     LONG_RESET_FLAG,
	output logic                     SW_RESET_FLAG,
	output logic                     ASYNC_RESET_FLAG
);
	localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN_CYCLES - 1);
	localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYCLES - 1);
	localparam logic [CNT_W-1:0] SMP_LAST = CNT_W'(CNT_SMP - 1);
	localparam logic [CNT_W-1:0] REL_LAST = CNT_W'(CNT_REL - 1);

	if (SEQ_CYCLES < 2 || SEQ_CYCLES > 2 ** CNT_W
		|| WIN_CYCLES < 1 || WIN_CYCLES > 2 ** CNT_W) begin : g_bad_param
		$error("rsc_reset_ctrl: sequence counts do not fit the counter");
	end

	rsc_ctl_t s_q;
	rsc_ctl_t s_d;
	logic     rst_low;
	logic     async_hit;

	rsc_seq_if sif ();

	rsc_low_timer #(
		.MIN (CNT_MIN_LOW),
		.W   (LOW_W)
	) u_low_timer (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.sif   (sif.tmr)
	);

	rsc_cfg_latch #(
		.W (CFG_W)
	) u_cfg_latch (
		.clk   (REF_CLK),
		.rst_n (RST_N),
		.sif   (sif.cfgl)
	);

	assign rst_low      = ~FILTERED_RESET_IN_N;
	assign sif.rst_low  = rst_low;
	assign sif.port_in  = CONFIG_PORT;
	assign sif.cap_full = s_q.cap_full;
	assign sif.cap_sw   = s_q.cap_sw;
	assign sif.transp   = s_q.transp;

	// A software sequence is immune to the powerdown pin; a running asynchronous one stays.
	assign async_hit = rst_low && !RESET_POWERDOWN_PIN && !s_q.sw // R17 R16
		&& s_q.st != ST_ASYNC;

	// Common entry into any reset sequence.
	function automatic rsc_ctl_t enter_f(input rsc_ctl_t s, input rsc_state_t st,
		input logic sw);
		rsc_ctl_t r;
		r = s;
		r.st          = st;
		r.cnt         = '0;
		r.sw          = sw;
		r.bidir_act   = s.bidir_en; // R7
		r.bidir_en    = 1'b0; // R7
		r.pd_oe       = (st == ST_WIN) && s.bidir_en; // R7
		r.rst_out_n   = 1'b0; // R5
		r.io_hz       = 1'b1; // R5
		r.abort       = 1'b1; // R6
		r.strobe_idle = 1'b1;
		r.cpu_run     = 1'b0;
		r.transp      = 1'b0;
		r.short_f     = 1'b0; // R25
		r.long_f      = 1'b0;
		r.sw_f        = 1'b0;
		r.async_f     = (st == ST_ASYNC);
		return r;
	endfunction : enter_f

	always_comb begin
		s_d = s_q;
		s_d.flash_rst = 1'b0;
		s_d.cap_full  = 1'b0;
		s_d.cap_sw    = 1'b0;
		s_d.rpd_pd    = rst_low | s_q.pd_oe; // R14
		if (SYSTEM_CONFIG_REGISTER_WR && s_q.cpu_run && !s_q.rst_out_n) begin
			s_d.bidir_en = SYSTEM_CONFIG_REGISTER_WDATA[SYSTEM_CONFIG_REGISTER_BIDIR_BIT]; // R7
		end
		if (END_OF_INIT_INSTRUCTION && s_q.cpu_run) begin
			s_d.rst_out_n = 1'b1; // R24
		end
		case (s_q.st)
			ST_RUN: begin
				s_d.flash_rst = sif.glitch; // R21
				if (sif.qual) begin
					s_d = enter_f(s_d, ST_WIN, 1'b0); // R4
				end else if (SOFTWARE_RESET_INSTRUCTION) begin
					s_d = enter_f(s_d, ST_SEQ, 1'b1); // R18
					s_d.pd_oe = s_q.bidir_en & RESET_POWERDOWN_PIN; // R20
				end
			end
			ST_WIN: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == WIN_LAST) begin
					s_d.st  = ST_SEQ; // R8
					s_d.cnt = '0;
				end
			end
			ST_SEQ: begin
				if (s_q.sw && !RESET_POWERDOWN_PIN) begin
					s_d.pd_oe = 1'b0; // R20
				end
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == SEQ_LAST) begin
					s_d.st    = ST_SMP; // R8
					s_d.cnt   = '0;
					s_d.pd_oe = 1'b0; // R11
				end
			end
			ST_SMP: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt == SMP_LAST) begin
					s_d.cnt = '0;
					if (rst_low) begin
						s_d.sw      = 1'b0;
						s_d.short_f = 1'b1; // R9
						s_d.long_f  = 1'b1; // R9
						s_d.transp  = 1'b1; // R10
						s_d.st      = ST_HOLD;
					end else begin
						s_d.short_f = !s_q.sw; // R9
						s_d.sw_f    = s_q.sw; // R25
						s_d.st      = ST_REL;
					end
				end
			end
			ST_HOLD: begin
				if (!rst_low) begin
					s_d.st  = ST_REL; // R13
					s_d.cnt = CNT_W'(1);
				end
			end
			ST_REL: begin
				s_d.cnt = s_q.cnt + 1'b1;
				if (s_q.cnt >= REL_LAST) begin
					s_d.transp = 1'b0; // R12
					s_d.st     = ST_FLASH;
				end
			end
			ST_FLASH: begin
				if (!EXTERNAL_ACCESS_SELECT || FLASH_INIT_DONE) begin // R13 R23
					s_d.st          = ST_RUN;
					s_d.cpu_run     = 1'b1;
					s_d.io_hz       = 1'b0;
					s_d.abort       = 1'b0;
					s_d.strobe_idle = 1'b0; // R2
					s_d.fetch       = RESET_VECTOR; // R3
					s_d.cap_full    = !s_q.sw; // R2
					s_d.cap_sw      = s_q.sw; // R19
					s_d.sw          = 1'b0;
				end
			end
			ST_ASYNC: begin
				s_d.pd_oe = 1'b0;
				if (!rst_low) begin
					s_d.st  = ST_REL; // R2
					s_d.cnt = CNT_W'(1);
				end
			end
			default: begin
				s_d = RSC_CTL_RST;
			end
		endcase
		if (async_hit) begin
			s_d = enter_f(s_d, ST_ASYNC, 1'b0); // R1 R15
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			s_q <= RSC_CTL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign RESET_OUT_N            = s_q.rst_out_n;
	assign RESET_IN_N_O           = 1'b0;
	assign RESET_IN_N_OE          = s_q.pd_oe;
	assign RPD_PULLDOWN_EN        = s_q.rpd_pd;
	assign IO_HIGHZ               = s_q.io_hz;
	assign BUS_ABORT              = s_q.abort;
	assign STROBES_IDLE           = s_q.strobe_idle;
	assign CPU_RUN                = s_q.cpu_run;
	assign FETCH_ADDR             = s_q.fetch;
	assign FLASH_RESET            = s_q.flash_rst;
	assign BIDIR_RESET_ENABLE     = s_q.bidir_en;
	assign CONFIG_LATCHED         = sif.cfg;
	assign CONFIG_CLK_TRANSPARENT = s_q.transp;
	assign SHORT_RESET_FLAG       = s_q.short_f;
	assign LONG_RESET_FLAG        = s_q.long_f;
	assign SW_RESET_FLAG          = s_q.sw_f;
	assign ASYNC_RESET_FLAG       = s_q.async_f;

	// Cycles spent in the internal sequence, read only by the checks below.
	logic [CNT_W:0] seq_len_q;

	always_ff @(posedge REF_CLK) begin
		if (!RST_N || s_q.st != ST_SEQ) begin
			seq_len_q <= '0;
		end else begin
			seq_len_q <= seq_len_q + 1'b1;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	chk_async_entry: assert property ( // R1
		(rst_low && !RESET_POWERDOWN_PIN && s_q.st == ST_RUN)
		|=> s_q.st == ST_ASYNC && !RESET_OUT_N && !CPU_RUN)
		else $error("Asynchronous reset not entered.");
	chk_async_escalate: assert property ( // R15
		(s_q.st inside {ST_WIN, ST_SEQ, ST_SMP, ST_HOLD} && !s_q.sw && rst_low
		&& !RESET_POWERDOWN_PIN) |=> s_q.st == ST_ASYNC ##1 s_q.st inside {ST_ASYNC, ST_REL})
		else $error("Synchronous reset did not turn asynchronous.");
	chk_sync_entry: assert property ( // R5
		(s_q.st == ST_RUN && sif.qual && RESET_POWERDOWN_PIN)
		|=> s_q.st == ST_WIN && !RESET_OUT_N && IO_HIGHZ && BUS_ABORT)
		else $error("Synchronous reset entry outputs wrong.");
	chk_seq_length: assert property ( // R8
		(s_q.st == ST_SEQ) ##1 (s_q.st == ST_SMP) |-> seq_len_q == (CNT_W + 1)'(SEQ_CYCLES))
		else $error("Internal sequence length wrong.");
	chk_bidir_hold: assert property ( // R11
		(s_q.st == ST_SEQ && !s_q.sw && s_q.bidir_act) |-> RESET_IN_N_OE
		##1 (s_q.st != ST_SMP || !RESET_IN_N_OE))
		else $error("Reset input pull-down not held for the sequence.");
	chk_bidir_cleared: assert property ( // R7
		(s_q.st != ST_RUN) |-> !BIDIR_RESET_ENABLE && (!RESET_IN_N_OE || s_q.bidir_act))
		else $error("Bidirectional enable survives a reset.");
	chk_classify_long: assert property ( // R9
		(s_q.st == ST_SMP && s_q.cnt == SMP_LAST && rst_low && (RESET_POWERDOWN_PIN || s_q.sw))
		|=> LONG_RESET_FLAG && SHORT_RESET_FLAG && CONFIG_CLK_TRANSPARENT)
		else $error("Long reset not classified.");
	chk_transp_release: assert property ( // R12
		(s_q.st == ST_HOLD && !rst_low) |=> CONFIG_CLK_TRANSPARENT ##1 !CONFIG_CLK_TRANSPARENT)
		else $error("Clock option transparency not ended in time.");
	chk_sw_bidir_rpd: assert property ( // R20
		(s_q.st == ST_SEQ && s_q.sw && !RESET_POWERDOWN_PIN) |=> !RESET_IN_N_OE)
		else $error("Software reset drives input while powerdown pin low.");
	chk_flash_wait: assert property ( // R13
		(s_q.st == ST_FLASH && EXTERNAL_ACCESS_SELECT && !FLASH_INIT_DONE)
		|=> s_q.st inside {ST_FLASH, ST_ASYNC} && !CPU_RUN)
		else $error("Exit before flash initialization.");
	chk_reset_out_n_end_of_init_instruction: assert property ( // R24
		$rose(RESET_OUT_N) |-> $past(END_OF_INIT_INSTRUCTION) && $past(CPU_RUN))
		else $error("Reset output released without end of init.");
	chk_fetch_zero: assert property ( // R3
		$rose(CPU_RUN) |-> FETCH_ADDR == RESET_VECTOR && !STROBES_IDLE)
		else $error("Restart address not zero.");
	chk_rpd_pulldown: assert property ( // R14
		rst_low |=> RPD_PULLDOWN_EN)
		else $error("Powerdown pin pull-down not enabled.");

	cov_long_reset: cover property ((s_q.st == ST_SMP) ##1 (s_q.st == ST_HOLD));
	cov_sw_reset: cover property ($rose(SW_RESET_FLAG));
	cov_sync_to_async: cover property ((s_q.st == ST_SEQ && !s_q.sw) ##1 (s_q.st == ST_ASYNC));
	cov_flash_only: cover property (FLASH_RESET);
endmodule : rsc_reset_ctrl

// ### tb/rsc_board.sv
// Board-side reset circuitry: a reset button held by a capacitor and the open-drain line.
// Assumes the bench raises hold_req to press the button and glitch_req only on purpose.
`timescale 1ns/1ns
module rsc_board (
	input  wire logic clk,
	input  wire logic hold_req,
	input  wire logic glitch_req,
	input  wire logic dev_o,
	input  wire logic dev_oe,
	output logic      rst_f_n
);
	// Cycles beyond 500 ns at the 10 ns clock.
	localparam int MIN_LOW = 51;
	int   low_cnt = 0;
	logic ext_low = 1'b0;

	// Once pressed, the line stays low past the filter minimum by one CPU clock.
	always @(posedge clk) begin
		if (hold_req && !ext_low) begin
			low_cnt <= MIN_LOW;
		end else if (low_cnt > 0) begin
			low_cnt <= low_cnt - 1;
		end
		ext_low <= hold_req || (low_cnt > 1);
	end

	// Wired-and of the board, the device drain and the pull-up of the line.
	assign rst_f_n = !ext_low && !glitch_req && (dev_oe ? dev_o : 1'b1);
endmodule : rsc_board

// ### tb/tb.sv
// Self-checking bench of the reset sequence controller with its board model.
// Assumes a 100 MHz clock and a shortened internal sequence to keep the run short.
`timescale 1ns/1ns
module tb;
	import rsc_pkg::*;
	localparam int SEQ = 64;
	localparam int WIN = 6;
	logic        clk    = 1'b0;
	logic        rst_n  = 1'b0;
	logic        hold   = 1'b0;
	logic        glitch = 1'b0;
	logic        reset_powerdown_pin    = 1'b1;
	logic        ea     = 1'b0;
	logic        fdone  = 1'b1;
	logic        software_reset_instruction   = 1'b0;
	logic        end_of_init_instruction  = 1'b0;
	logic        sc_wr  = 1'b0;
	logic [15:0] sc_wd  = 16'h0008;
	logic [15:0] cfg    = 16'h1234;
	logic        f_n, rout_n, oe, o, pd, hz, abrt, idle, run, frst, bidir, transp;
	logic        f_sh, f_lg, f_sw, f_as;
	logic [23:0] fetch;
	logic [15:0] cfg_l, old;
	logic        s_oe = 1'b0, s_tr = 1'b0, s_pd = 1'b0, s_fr = 1'b0;
	int          fail_count = 0;
	int          n_tests = 0;
	int          n;

	always #5 clk = ~clk;

	rsc_board u_rsc_board (
		.clk        (clk),
		.hold_req   (hold),
		.glitch_req (glitch),
		.dev_o      (o),
		.dev_oe     (oe),
		.rst_f_n    (f_n)
	);

	rsc_reset_ctrl #(.SEQ_CYCLES(SEQ), .WIN_CYCLES(WIN)) u_rsc_reset_ctrl (
		.REF_CLK                    (clk),
		.RST_N                      (rst_n),
		.FILTERED_RESET_IN_N        (f_n),
		.RESET_POWERDOWN_PIN        (reset_powerdown_pin),
		.EXTERNAL_ACCESS_SELECT     (ea),
		.FLASH_INIT_DONE            (fdone),
		.SOFTWARE_RESET_INSTRUCTION (software_reset_instruction),
		.END_OF_INIT_INSTRUCTION    (end_of_init_instruction),
		.SYSTEM_CONFIG_REGISTER_WR                  (sc_wr),
		.SYSTEM_CONFIG_REGISTER_WDATA               (sc_wd),
		.CONFIG_PORT                (cfg),
		.RESET_OUT_N                (rout_n),
		.RESET_IN_N_O               (o),
		.RESET_IN_N_OE              (oe),
		.RPD_PULLDOWN_EN            (pd),
		.IO_HIGHZ                   (hz),
		.BUS_ABORT                  (abrt),
		.STROBES_IDLE               (idle),
		.CPU_RUN                    (run),
		.FETCH_ADDR                 (fetch),
		.FLASH_RESET                (frst),
		.BIDIR_RESET_ENABLE         (bidir),
		.CONFIG_LATCHED             (cfg_l),
		.CONFIG_CLK_TRANSPARENT     (transp),
		.SHORT_RESET_FLAG           (f_sh),
		.LONG_RESET_FLAG            (f_lg),
		.SW_RESET_FLAG              (f_sw),
		.ASYNC_RESET_FLAG           (f_as)
	);

	// Sticky records of short pulses, taken away from the rising edge.
	always @(negedge clk) begin
		s_oe = s_oe | oe;
		s_tr = s_tr | transp;
		s_pd = s_pd | pd;
		s_fr = s_fr | frst;
	end

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick

	task automatic clr();
		s_oe = 1'b0;
		s_tr = 1'b0;
		s_pd = 1'b0;
		s_fr = 1'b0;
	endtask : clr

	task automatic wait_run(input int lim, output int cnt);
		cnt = 0;
		while (run !== 1'b1 && cnt < lim) begin
			tick(1);
			cnt++;
		end
		if (run !== 1'b1) begin
			fail_count++;
			$display("Error at %0t: timeout waiting for the CPU to run", $time);
			print_verdict();
		end
	endtask : wait_run

	task automatic system_config_register_set();
		@(posedge clk) sc_wr <= 1'b1;
		@(posedge clk) sc_wr <= 1'b0;
		tick(1);
		chk(bidir, 1'b1);
	endtask : system_config_register_set

	task automatic pulse_sw();
		@(posedge clk) software_reset_instruction <= 1'b1;
		@(posedge clk) software_reset_instruction <= 1'b0;
		tick(1);
	endtask : pulse_sw

	initial begin
		tick(20);
		@(posedge clk) rst_n <= 1'b1;
		tick(1);
		clr();
		wait_run(50, n);
		tick(2);
		chk(f_as, 1'b1);
		chk(cfg_l, cfg);
		chk(fetch, 24'h00_0000);
		chk({idle, hz, abrt}, 3'h0);
		chk({rout_n, bidir}, 2'h0);
		// Powerdown pin low with the reset input high, then a one-cycle glitch.
		@(posedge clk) reset_powerdown_pin <= 1'b0;
		tick(5);
		chk(run, 1'b1);
		@(posedge clk) reset_powerdown_pin <= 1'b1;
		glitch <= 1'b1;
		@(posedge clk) glitch <= 1'b0;
		tick(4);
		chk({s_fr, run}, 2'h3);
		// Short hardware reset with the device pulling the line.
		system_config_register_set();
		clr();
		@(posedge clk) hold <= 1'b1;
		@(posedge clk) hold <= 1'b0;
		tick(5);
		chk({rout_n, hz, abrt}, 3'b011);
		wait_run(300, n);
		chk(n >= SEQ + WIN && n <= SEQ + WIN + 10, 1'b1);
		chk({s_oe, s_pd, oe, bidir, o}, 5'b11000);
		chk(fetch, 24'h00_0000);
		chk(rout_n, 1'b0);
		@(posedge clk) end_of_init_instruction <= 1'b1;
		@(posedge clk) end_of_init_instruction <= 1'b0;
		tick(1);
		chk(rout_n, 1'b1);
		chk({f_sh, f_lg, f_sw, f_as}, 4'b1000);
		// Long hardware reset with new clock options on the port.
		clr();
		@(posedge clk) hold <= 1'b1;
		tick(150);
		@(posedge clk) cfg <= 16'hA5F0;
		tick(50);
		chk({run, transp}, 2'b01);
		chk(cfg_l, 16'hB234);
		@(posedge clk) hold <= 1'b0;
		wait_run(20, n);
		chk(n <= 6, 1'b1);
		chk(transp, 1'b0);
		tick(2);
		chk(cfg_l, 16'hA5F0);
		chk({f_sh, f_lg, s_tr}, 3'b111);
		// Software reset, device pulling the line while the powerdown pin is high.
		system_config_register_set();
		old = cfg_l;
		clr();
		@(posedge clk) cfg <= 16'h0F0F;
		pulse_sw();
		wait_run(200, n);
		tick(2);
		chk({f_sw, f_lg, f_as}, 3'b100);
		chk(s_oe, 1'b1);
		chk(cfg_l, {old[15:13], cfg[12:8], 6'h3F, old[1:0]});
		// Software reset with the powerdown pin low.
		system_config_register_set();
		clr();
		@(posedge clk) reset_powerdown_pin <= 1'b0;
		pulse_sw();
		wait_run(200, n);
		chk({s_oe, f_sw, f_as}, 3'b010);
		// Synchronous reset escalated to asynchronous, booting from flash.
		clr();
		@(posedge clk) reset_powerdown_pin <= 1'b1;
		hold <= 1'b1;
		ea <= 1'b1;
		fdone <= 1'b0;
		tick(20);
		chk({f_as, rout_n, hz, run}, 4'b0010);
		@(posedge clk) reset_powerdown_pin <= 1'b0;
		tick(3);
		chk({f_as, run}, 2'b10);
		@(posedge clk) reset_powerdown_pin <= 1'b1;
		hold <= 1'b0;
		tick(60);
		chk({run, f_as}, 2'b01);
		@(posedge clk) fdone <= 1'b1;
		wait_run(10, n);
		chk({f_as, idle}, 2'b10);
		@(posedge clk) ea <= 1'b0;
		tick(2);
		// Asynchronous reset straight from run, booting externally.
		clr();
		@(posedge clk) reset_powerdown_pin <= 1'b0;
		hold <= 1'b1;
		tick(3);
		chk({f_as, run, hz, s_pd}, 4'b1011);
		@(posedge clk) reset_powerdown_pin <= 1'b1;
		hold <= 1'b0;
		wait_run(100, n);
		tick(2);
		chk({f_as, idle, hz}, 3'b100);
		chk(cfg_l, 16'h0F0F);
		chk(fetch, 24'h00_0000);
		print_verdict();
	end
endmodule : tb
